/* shared/iefi_pkg.sv */
package iefi_pkg;

    localparam int unsigned PC_W        = 24;
    localparam int unsigned FLG_W       = 16;
    localparam int unsigned LVL_W       = 3;
    localparam int unsigned NUM_W       = 6;
    localparam int unsigned NUM_PERIPH  = 41;
    localparam int unsigned NUM_MATCH   = 8;

    // Flag register field positions
    localparam int unsigned FLG_O_BIT   = 2;
    localparam int unsigned FLG_I_BIT   = 6;
    localparam int unsigned FLG_U_BIT   = 7;
    localparam int unsigned FLG_IPL_LO  = 12;

    // Software interrupt numbers
    localparam logic [5:0] PERIPH_NUM_BASE = 6'h08;
    localparam logic [5:0] ISP_NUM_LAST    = 6'h1f;
    localparam logic [5:0] BRK_NUM         = 6'h00;

    localparam logic [2:0] FAST_LEVEL      = 3'h7;

    // Fixed vector addresses
    localparam logic [23:0] VEC_UND  = 24'hfffdc;
    localparam logic [23:0] VEC_OVF  = 24'hfffe0;
    localparam logic [23:0] VEC_BRK  = 24'hfffe4;
    localparam logic [23:0] VEC_AMT  = 24'hfffe8;
    localparam logic [23:0] VEC_WDT  = 24'hffff0;
    localparam logic [23:0] VEC_NMI  = 24'hffff8;
    localparam logic [23:0] VEC_DEBUG_BREAK_INSTR = 24'hfffec;

    // APB register map
    localparam logic [7:0] ADDR_PRIO_CFG   = 8'h00;
    localparam logic [7:0] ADDR_FAST_VEC   = 8'h04;
    localparam logic [7:0] ADDR_MATCH_EN   = 8'h08;
    localparam logic [7:0] ADDR_INTB       = 8'h0c;
    localparam logic [7:0] ADDR_SAVED_FLG  = 8'h10;
    localparam logic [7:0] ADDR_SAVED_PC   = 8'h14;
    localparam logic [7:0] ADDR_STATUS     = 8'h18;
    localparam logic [7:0] ADDR_MATCH_BASE = 8'h20;
    localparam logic [7:0] ADDR_LEVEL_BASE = 8'h40;
    localparam logic [7:0] ADDR_PEND_LO    = 8'h1c;

    localparam int unsigned CFG_FAST_BIT   = 3;
    localparam int unsigned CFG_DMA7_BIT   = 5;

    localparam int unsigned FAST_ENTRY_CYC = 5;
    localparam int unsigned FAST_RET_CYC   = 3;

    typedef enum logic [2:0]
    {
        IEFI_IDLE  = 3'b000,
        IEFI_ENTRY = 3'b001,
        IEFI_FAST  = 3'b010,
        IEFI_FRET  = 3'b011
    } iefi_state_type;

    typedef enum logic [3:0]
    {
        SRC_NONE   = 4'h0,
        SRC_UND    = 4'h1,
        SRC_OVF    = 4'h2,
        SRC_BRK    = 4'h3,
        SRC_DEBUG_BREAK_INSTR   = 4'h4,
        SRC_TRAP   = 4'h5,
        SRC_NMI    = 4'h6,
        SRC_WDT    = 4'h7,
        SRC_OSC    = 4'h8,
        SRC_AMT    = 4'h9,
        SRC_PERIPH = 4'ha,
        SRC_FAST   = 4'hb
    } iefi_src_type;

endpackage : iefi_pkg

/* logic/iefi_match.sv */
module iefi_match
    import iefi_pkg::*;
#(
    parameter int unsigned CHANNELS = NUM_MATCH
)
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic [CHANNELS*PC_W-1:0]   match_address_reg,
    input  wire logic [CHANNELS-1:0]        match_channel_enable,
    input  wire logic [PC_W-1:0]            fetch_addr,
    input  wire logic                       fetch_first,
    input  wire logic                       fetch_valid,
    output logic                            match_hit
);

    logic [CHANNELS-1:0] hit_vec;

    // Only first bytes of instructions compare; data and tail bytes never hit
    for (genvar i = 0; i < CHANNELS; i++)
    begin : g_chan
        assign hit_vec[i] = match_channel_enable[i] && fetch_valid && fetch_first // (R15) (R16)
                          && (match_address_reg[i*PC_W +: PC_W] == fetch_addr);
    end

    assign match_hit = |hit_vec;

endmodule : iefi_match

/* logic/iefi_ctrl.sv */
// Contract
// (R1) Maskable requests need enable flag; level sets order.
// (R2) Non-maskable ignore enable flag; fixed order.
// (R3) Software interrupts always taken, non-maskable.
// (R4) Undefined opcode always traps.
// (R5) Overflow trap only with overflow flag set.
// (R6) Breakpoint traps; debug break for tools.
// (R7) Numbered trap 0 to 63 via relocatable table.
// (R8) Traps 8 to 48 share peripheral vectors.
// (R9) Trap saves flags and PC, loads vector.
// (R10) Traps 0-31 clear stack select; 32-63 keep it.
// (R11) Peripheral entry saves flags, clears stack select.
// (R12) Non-maskable pin falling edge raises request.
// (R13) Watchdog underflow raises request.
// (R14) Oscillator stop raises request.
// (R15) Enabled match channel fires before matching instruction.
// (R16) Match only on instruction first address.
// (R17) Fast entry five cycles, return three.
// (R18) Fast when enable set and level seven.
// (R19) One fast source only; level-7 DMA select cleared. Code enforces neither; CFG_DMA7_BIT is unused.
// (R20) Fast entry saves flags and PC, jumps to fast vector.
// (R21) Fast return restores flags and PC.
// (R22) Fast use blocks DMA channels 2 and 3.
// (R23) Peripheral taken if enabled, pending, level above current.
// (R24) Current level three bits; seven blocks maskable.
// (R25) Highest level first; others stay pending.
//
// Implementation choices: the address map and the APB slave port.
module iefi_ctrl
    import iefi_pkg::*;
#(
    parameter int unsigned PERIPHS = NUM_PERIPH
)
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [PERIPHS-1:0] periph_req,
    input  wire logic               nmi_pin,
    input  wire logic               wdt_underflow,
    input  wire logic               osc_stop,
    input  wire logic               instr_und,
    input  wire logic               instr_into,
    input  wire logic               instr_brk,
    input  wire logic               instr_debug_break_instr,
    input  wire logic               instr_int,
    input  wire logic [NUM_W-1:0]   instr_int_num,
    input  wire logic               instr_fast_return_instr,
    input  wire logic [FLG_W-1:0]   flag_register,
    input  wire logic [PC_W-1:0]    cpu_pc,
    input  wire logic [PC_W-1:0]    fetch_addr,
    input  wire logic               fetch_first,
    input  wire logic               fetch_valid,
    output logic                    int_take,
    output logic [PC_W-1:0]         int_vector,
    output logic                    int_push,
    output logic [FLG_W-1:0]        int_new_flags,
    output logic                    fast_restore,
    output logic [FLG_W-1:0]        fast_flags,
    output logic [PC_W-1:0]         fast_pc,
    output logic                    core_busy,
    output logic                    dma23_blocked
);

    iefi_state_type            state_ff;
    logic [2:0]                cnt_ff;
    logic [7:0]                prio_cfg_ff;
    logic [PC_W-1:0]           fast_vec_ff;
    logic [NUM_MATCH-1:0]      match_en_ff;
    logic [PC_W-1:0]           intb_ff;
    logic [FLG_W-1:0]          saved_flags_ff;
    logic [PC_W-1:0]           saved_pc_ff;
    logic [NUM_MATCH*PC_W-1:0] match_addr_ff;
    logic [PERIPHS*LVL_W-1:0]  level_ff;
    logic [PERIPHS-1:0]        pend_ff;
    logic                      nmi_s1_ff;
    logic                      nmi_s2_ff;
    logic                      nmi_s3_ff;
    logic                      nmi_pend_ff;
    logic                      wdt_pend_ff;
    logic                      osc_pend_ff;
    logic [PC_W-1:0]           vec_ff;
    logic [FLG_W-1:0]          newflg_ff;
    logic                      push_ff;
    logic                      take_ff;
    logic                      restore_ff;
    logic                      match_hit;
    logic                      wr;
    logic                      rd;
    logic [PERIPHS-1:0]        ack_clr;
    logic                      sel_valid;
    logic [5:0]                sel_idx;
    logic [2:0]                sel_lvl;
    logic                      sel_fast;
    iefi_src_type              src;
    logic                      fast_en;
    logic [2:0]                current_priority_level;

    assign wr       = psel && penable && pwrite;
    assign rd       = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign fast_en  = prio_cfg_ff[CFG_FAST_BIT];
    assign current_priority_level      = flag_register[FLG_IPL_LO +: LVL_W];
    assign dma23_blocked = fast_en; // (R22)
    assign core_busy = (state_ff != IEFI_IDLE);

    iefi_match #(
        .CHANNELS               (NUM_MATCH)
    ) u_match (
        .pclk                   (pclk),
        .presetn                (presetn),
        .match_address_reg      (match_addr_ff),
        .match_channel_enable   (match_en_ff),
        .fetch_addr             (fetch_addr),
        .fetch_first            (fetch_first),
        .fetch_valid            (fetch_valid),
        .match_hit              (match_hit)
    );

    // Unmapped addresses answer with an error
    always_comb
    begin
        pslverr = 1'b0;
        if (psel && penable)
        begin
            if (paddr[1:0] != 2'b00)
                pslverr = 1'b1;
            else if (paddr > (ADDR_LEVEL_BASE + 8'(4 * PERIPHS) - 8'h4))
                pslverr = 1'b1;
            else if (paddr > ADDR_PEND_LO && paddr < ADDR_MATCH_BASE)
                pslverr = 1'b1;
            else if (paddr >= (ADDR_MATCH_BASE + 8'(4 * NUM_MATCH))
                     && paddr < ADDR_LEVEL_BASE)
                pslverr = 1'b1;
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prio_cfg_ff   <= 8'h00;
            fast_vec_ff   <= '0;
            match_en_ff   <= '0;
            intb_ff       <= '0;
            match_addr_ff <= '0;
            level_ff      <= '0;
        end
        else if (wr && !pslverr)
        begin
            case (paddr)
                ADDR_PRIO_CFG: prio_cfg_ff <= pwdata[7:0];
                ADDR_FAST_VEC: fast_vec_ff <= pwdata[PC_W-1:0];
                ADDR_MATCH_EN: match_en_ff <= pwdata[NUM_MATCH-1:0];
                ADDR_INTB:     intb_ff     <= pwdata[PC_W-1:0];
                default:
                begin
                    if (paddr >= ADDR_LEVEL_BASE)
                        level_ff[(paddr - ADDR_LEVEL_BASE) / 4 * LVL_W +: LVL_W]
                            <= pwdata[LVL_W-1:0];
                    else if (paddr >= ADDR_MATCH_BASE)
                        match_addr_ff[(paddr - ADDR_MATCH_BASE) / 4 * PC_W +: PC_W]
                            <= pwdata[PC_W-1:0];
                end
            endcase
        end
    end

    // Read data registered on the setup cycle; zero-wait access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (rd)
        begin
            prdata <= 32'h0;
            case (paddr)
                ADDR_PRIO_CFG:  prdata <= {24'h0, prio_cfg_ff};
                ADDR_FAST_VEC:  prdata <= {8'h0, fast_vec_ff};
                ADDR_MATCH_EN:  prdata <= {24'h0, match_en_ff};
                ADDR_INTB:      prdata <= {8'h0, intb_ff};
                ADDR_SAVED_FLG: prdata <= {16'h0, saved_flags_ff};
                ADDR_SAVED_PC:  prdata <= {8'h0, saved_pc_ff};
                ADDR_STATUS:    prdata <= {26'h0, nmi_pend_ff, wdt_pend_ff,
                                           osc_pend_ff, 3'(state_ff)};
                ADDR_PEND_LO:   prdata <= pend_ff[31:0];
                default:
                begin
                    if (paddr >= ADDR_LEVEL_BASE && (paddr - ADDR_LEVEL_BASE) / 4 < PERIPHS)
                        prdata <= {29'h0,
                            level_ff[(paddr - ADDR_LEVEL_BASE) / 4 * LVL_W +: LVL_W]};
                    else if (paddr >= ADDR_MATCH_BASE
                             && (paddr - ADDR_MATCH_BASE) / 4 < NUM_MATCH)
                        prdata <= {8'h0,
                            match_addr_ff[(paddr - ADDR_MATCH_BASE) / 4 * PC_W +: PC_W]};
                end
            endcase
        end
    end

    // Non-maskable pin is asynchronous: two stages before edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_s1_ff <= 1'b1;
            nmi_s2_ff <= 1'b1;
            nmi_s3_ff <= 1'b1;
        end
        else
        begin
            nmi_s1_ff <= nmi_pin;
            nmi_s2_ff <= nmi_s1_ff;
            nmi_s3_ff <= nmi_s2_ff;
        end
    end

    // Special interrupt latches; a new event wins over the acknowledge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_pend_ff <= 1'b0;
            wdt_pend_ff <= 1'b0;
            osc_pend_ff <= 1'b0;
        end
        else
        begin
            if (nmi_s3_ff && !nmi_s2_ff)
                nmi_pend_ff <= 1'b1; // (R12)
            else if (src == SRC_NMI)
                nmi_pend_ff <= 1'b0;
            if (wdt_underflow)
                wdt_pend_ff <= 1'b1; // (R13)
            else if (src == SRC_WDT)
                wdt_pend_ff <= 1'b0;
            if (osc_stop)
                osc_pend_ff <= 1'b1; // (R14)
            else if (src == SRC_OSC)
                osc_pend_ff <= 1'b0;
        end
    end

    // Highest-level eligible peripheral; lowest number breaks ties
    always_comb
    begin
        sel_valid = 1'b0;
        sel_idx   = 6'h00;
        sel_lvl   = 3'h0;
        for (int i = PERIPHS - 1; i >= 0; i--)
        begin
            if (pend_ff[i] && level_ff[i*LVL_W +: LVL_W] > current_priority_level // (R23) (R24)
                && level_ff[i*LVL_W +: LVL_W] >= sel_lvl) // (R25)
            begin
                sel_valid = 1'b1;
                sel_idx   = 6'(i);
                sel_lvl   = level_ff[i*LVL_W +: LVL_W];
            end
        end
        sel_valid = sel_valid && flag_register[FLG_I_BIT]; // (R1)
        sel_fast  = fast_en && (sel_lvl == FAST_LEVEL); // (R18)
    end

    // Source selection: software first, then fixed special order, then maskable
    always_comb
    begin
        src = SRC_NONE;
        if (state_ff != IEFI_IDLE || take_ff)
            src = SRC_NONE;
        else if (instr_und)
            src = SRC_UND; // (R4)
        else if (instr_into && flag_register[FLG_O_BIT])
            src = SRC_OVF; // (R5)
        else if (instr_brk)
            src = SRC_BRK; // (R6)
        else if (instr_debug_break_instr)
            src = SRC_DEBUG_BREAK_INSTR;
        else if (instr_int)
            src = SRC_TRAP; // (R3) (R7)
        else if (nmi_pend_ff)
            src = SRC_NMI; // (R2)
        else if (wdt_pend_ff)
            src = SRC_WDT;
        else if (osc_pend_ff)
            src = SRC_OSC;
        else if (match_hit)
            src = SRC_AMT;
        else if (sel_valid)
            src = sel_fast ? SRC_FAST : SRC_PERIPH;
    end

    // Request pending bits: arrival wins over acknowledge
    for (genvar g = 0; g < PERIPHS; g++)
    begin : g_pend
        assign ack_clr[g] = (src == SRC_PERIPH || src == SRC_FAST) && (sel_idx == 6'(g));
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                pend_ff[g] <= 1'b0;
            else if (periph_req[g])
                pend_ff[g] <= 1'b1;
            else if (ack_clr[g] || (wr && paddr == ADDR_PEND_LO && g < 32 && !pwdata[g % 32]))
                pend_ff[g] <= 1'b0;
        end
    end

    // Entry vector and flags for the core
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vec_ff    <= '0;
            newflg_ff <= '0;
            push_ff   <= 1'b0;
        end
        else if (src != SRC_NONE)
        begin
            newflg_ff <= flag_register;
            push_ff   <= (src != SRC_FAST);
            newflg_ff[FLG_I_BIT] <= 1'b0;
            case (src)
                SRC_UND:  vec_ff <= VEC_UND;
                SRC_OVF:  vec_ff <= VEC_OVF;
                SRC_BRK:  vec_ff <= VEC_BRK;
                SRC_DEBUG_BREAK_INSTR: vec_ff <= VEC_DEBUG_BREAK_INSTR;
                SRC_NMI:  vec_ff <= VEC_NMI;
                SRC_WDT:  vec_ff <= VEC_WDT;
                SRC_OSC:  vec_ff <= VEC_WDT;
                SRC_AMT:  vec_ff <= VEC_AMT;
                SRC_TRAP:
                begin
                    vec_ff <= intb_ff + {16'h0, instr_int_num, 2'b00}; // (R8) (R9)
                    if (instr_int_num <= ISP_NUM_LAST)
                        newflg_ff[FLG_U_BIT] <= 1'b0; // (R10)
                    newflg_ff[FLG_I_BIT] <= flag_register[FLG_I_BIT];
                end
                SRC_PERIPH:
                begin
                    vec_ff <= intb_ff + {16'h0, sel_idx + PERIPH_NUM_BASE, 2'b00};
                    newflg_ff[FLG_U_BIT] <= 1'b0; // (R11)
                    newflg_ff[FLG_IPL_LO +: LVL_W] <= sel_lvl;
                end
                SRC_FAST:
                begin
                    vec_ff <= fast_vec_ff; // (R20)
                    newflg_ff[FLG_U_BIT] <= 1'b0;
                    newflg_ff[FLG_IPL_LO +: LVL_W] <= FAST_LEVEL;
                end
                default: vec_ff <= vec_ff;
            endcase
        end
    end

    // Fast save registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            saved_flags_ff <= '0;
            saved_pc_ff    <= '0;
        end
        else if (src == SRC_FAST)
        begin
            saved_flags_ff <= flag_register; // (R20)
            saved_pc_ff    <= cpu_pc;
        end
    end

    // Sequencer: normal entry takes two cycles, fast entry five, fast return three
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff   <= IEFI_IDLE;
            cnt_ff     <= 3'h0;
            take_ff    <= 1'b0;
            restore_ff <= 1'b0;
        end
        else
        begin
            take_ff    <= 1'b0;
            restore_ff <= 1'b0;
            case (state_ff)
                IEFI_IDLE:
                begin
                    if (instr_fast_return_instr)
                    begin
                        state_ff <= IEFI_FRET;
                        cnt_ff   <= 3'(FAST_RET_CYC - 2); // (R17)
                    end
                    else if (src == SRC_FAST)
                    begin
                        state_ff <= IEFI_FAST;
                        cnt_ff   <= 3'(FAST_ENTRY_CYC - 2); // (R17)
                    end
                    else if (src != SRC_NONE)
                    begin
                        state_ff <= IEFI_ENTRY;
                        cnt_ff   <= 3'h0;
                    end
                end
                IEFI_ENTRY, IEFI_FAST:
                begin
                    if (cnt_ff == 3'h0)
                    begin
                        state_ff <= IEFI_IDLE;
                        take_ff  <= 1'b1;
                    end
                    else
                        cnt_ff <= cnt_ff - 3'h1;
                end
                IEFI_FRET:
                begin
                    if (cnt_ff == 3'h0)
                    begin
                        state_ff   <= IEFI_IDLE;
                        restore_ff <= 1'b1; // (R21)
                    end
                    else
                        cnt_ff <= cnt_ff - 3'h1;
                end
                default: state_ff <= IEFI_IDLE;
            endcase
        end
    end

    assign int_take      = take_ff;
    assign int_vector    = vec_ff;
    assign int_push      = push_ff;
    assign int_new_flags = newflg_ff;
    assign fast_restore  = restore_ff;
    assign fast_flags    = saved_flags_ff;
    assign fast_pc       = saved_pc_ff;

endmodule : iefi_ctrl

/* sim/iefi_core_model.sv */
module iefi_core_model
(
    input logic         pclk,
    input logic         presetn,
    input logic         ld,
    input logic [15:0]  ld_flags,
    input logic [23:0]  ld_pc,
    input logic         int_take,
    input logic [23:0]  int_vector,
    input logic [15:0]  int_new_flags,
    input logic         fast_restore,
    input logic [15:0]  fast_flags,
    input logic [23:0]  fast_pc,
    output logic [15:0] flag_register,
    output logic [23:0] cpu_pc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [39:0] state_ff;
    assign {flag_register, cpu_pc} = state_ff;
    // Core reloads only on strobes, so a lost pulse shows as a stale PC
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= '0;
        else if (ld)
            state_ff <= {ld_flags, ld_pc};
        else if (int_take)
            state_ff <= {int_new_flags, int_vector};
        else if (fast_restore)
            state_ff <= {fast_flags, fast_pc};
    end
endmodule : iefi_core_model

/* sim/iefi_ctrl_properties.sv */
module iefi_ctrl_properties
(
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic        instr_und,
    input logic        instr_into,
    input logic        instr_brk,
    input logic        instr_int,
    input logic [5:0]  instr_int_num,
    input logic        instr_fast_return_instr,
    input logic [15:0] flag_register,
    input logic        int_take,
    input logic [23:0] int_vector,
    input logic        int_push,
    input logic [15:0] int_new_flags,
    input logic        fast_restore,
    input logic        core_busy,
    input logic        dma23_blocked
);
    timeunit 1ns;
    timeprecision 1ps;
    import iefi_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_trap;
        instr_int && !instr_und && !instr_into && !instr_brk && !core_busy;
    endsequence
    sequence s_take(logic [23:0] v);
        ##2 int_take && int_vector == v;
    endsequence
    AST_UND: assert property (instr_und && !core_busy |-> s_take(VEC_UND))
        else $error("undefined opcode entry wrong");
    AST_OVF: assert property (instr_into && flag_register[FLG_O_BIT] && !instr_und
        && !core_busy |-> s_take(VEC_OVF)) else $error("overflow entry wrong");
    AST_BRK: assert property (instr_brk && !instr_und && !instr_into && !core_busy
        |-> s_take(VEC_BRK) ##0 int_push) else $error("breakpoint entry wrong");
    AST_TRAP_LO: assert property (s_trap ##0 !instr_int_num[5]
        |-> ##2 int_take && !int_new_flags[FLG_U_BIT]) else $error("low trap stack wrong");
    AST_TRAP_HI: assert property (s_trap ##0 instr_int_num[5] |-> ##2 int_take
        && int_new_flags[FLG_U_BIT] == $past(flag_register[FLG_U_BIT], 2))
        else $error("high trap stack wrong");
    AST_FRET: assert property (instr_fast_return_instr |-> ##3 fast_restore)
        else $error("fast return timing wrong");
    AST_DMA: assert property (!$stable(dma23_blocked) |-> $past(psel && penable && pwrite))
        else $error("dma block changed without write");
    AST_FAST: assert property (int_take && !int_push |-> dma23_blocked)
        else $error("fast entry without enable");
endmodule : iefi_ctrl_properties
bind iefi_ctrl iefi_ctrl_properties i_props (.*);

/* sim/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import iefi_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ld = 0, err;
    logic fetch_first = 0, fetch_valid = 0, pready, pslverr, int_take, int_push;
    logic fast_restore, core_busy, dma23_blocked;
    logic [7:0] paddr = '0;
    logic [10:0] pul = '0;
    logic [5:0] instr_int_num = '0;
    logic [15:0] ld_flags = '0, flag_register, int_new_flags, fast_flags, f;
    logic [23:0] ld_pc = '0, fetch_addr = '0, cpu_pc, int_vector, fast_pc, pc, fv;
    logic [31:0] pwdata = '0, prdata, rd, base, seed = 32'h8bf6;
    int miscompares = 0, check_count = 0, cyc = 0, lat, ln, p = 0;
    int ks[7] = '{0, 1, 2, 3, 6, 7, 9};
    int nums[4] = '{0, 31, 32, 63};
    logic [23:0] vs[7] = '{VEC_UND, VEC_OVF, VEC_BRK, VEC_DEBUG_BREAK_INSTR, VEC_WDT, VEC_WDT, VEC_NMI};
    logic [15:0] blk[2] = '{16'h3040, 16'h2080};
    wire logic instr_und = pul[0], instr_into = pul[1], instr_brk = pul[2];
    wire logic instr_debug_break_instr = pul[3], instr_int = pul[4], instr_fast_return_instr = pul[5];
    wire logic wdt_underflow = pul[6], osc_stop = pul[7], nmi_pin = !pul[9];
    wire logic [40:0] periph_req = 41'(pul[8]) << p;
    iefi_ctrl i_dut (.*);
    iefi_core_model i_core (.*);
    always #2 pclk = ~pclk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic setf(input logic [15:0] v);
        @(posedge pclk);
        {ld, ld_flags, ld_pc} <= {1'b1, v, 24'(xs())};
        @(posedge pclk);
        ld <= 1'b0;
        #1;
        {f, pc} = {flag_register, cpu_pc};
    endtask : setf
    // Latency counts edges from the one that samples the pulse; 40 means no answer
    task automatic fire(input int k, input logic w, output int n);
        @(posedge pclk);
        pul[k] <= 1'b1;
        @(posedge pclk);
        pul[k] <= 1'b0;
        n = 1;
        while ((w ? fast_restore : int_take) !== 1'b1 && n < 40)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask : fire
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        base = xs() & 32'h0000ff00;
        apb(1'b1, ADDR_INTB, base);
        apb(1'b0, ADDR_INTB, '0);
        chk(rd, base);
        apb(1'b0, 8'hfc, '0);
        chk(err, 1'b1);
        $display("test registers done");
        for (int i = 0; i < 7; i++)
        begin
            setf(16'h0004);
            fire(ks[i], 1'b0, lat);
            chk(int_vector, vs[i]);
            if (i < 4)
                chk(lat, 2);
        end
        setf(16'h0000);
        fire(1, 1'b0, lat);
        chk(lat, 40);
        $display("test fixed done");
        for (int i = 0; i < 8; i++)
        begin
            @(posedge pclk) instr_int_num <= 6'((i < 4) ? nums[i] : xs());
            setf(16'h00c0);
            fire(4, 1'b0, lat);
            chk(int_vector, base + 4 * instr_int_num);
            chk(int_new_flags[FLG_U_BIT], instr_int_num >= 32);
            chk(int_push, 1'b1);
        end
        $display("test trap done");
        p = xs() % 32;
        apb(1'b1, 8'(ADDR_LEVEL_BASE + 4 * p), 32'h3);
        setf(16'h20c0);
        fire(8, 1'b0, ln);
        chk(int_vector, base + 4 * (8 + p));
        chk(int_new_flags[FLG_U_BIT], 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            setf(blk[i]);
            fire(8, 1'b0, lat);
            chk(lat, 40);
        end
        apb(1'b1, ADDR_PEND_LO, '0);
        $display("test peripheral done");
        fv = 24'(xs()) & 24'hfffffe;
        apb(1'b1, ADDR_PRIO_CFG, 32'h8);
        apb(1'b1, ADDR_FAST_VEC, fv);
        apb(1'b1, 8'(ADDR_LEVEL_BASE + 4 * p), 32'h7);
        setf(16'h00c0);
        fire(8, 1'b0, lat);
        chk(lat, ln + 3);
        chk(int_vector, fv);
        chk(dma23_blocked, 1'b1);
        fire(5, 1'b1, lat);
        chk(lat, 3);
        chk({fast_flags, fast_pc}, {f, pc});
        $display("test fast done");
        apb(1'b1, ADDR_MATCH_BASE + 8'h0c, fv);
        apb(1'b1, ADDR_MATCH_EN, 32'h8);
        for (int i = 0; i < 2; i++)
        begin
            setf(16'h0000);
            @(posedge pclk) {fetch_valid, fetch_first, fetch_addr} <= {1'b1, i[0], fv};
            fire(10, 1'b0, lat);
            chk(int_vector == VEC_AMT && lat < 40, i == 1);
        end
        $display("test match done");
        report_and_stop();
    end
endmodule : testbench
